// ===== logic/tcs_pkg.sv
// constants shared by the timer channel status and interrupt logic
package tcs_pkg;

   // widths
   localparam int unsigned FLAG_W   = 8;
   localparam int unsigned DATA_W   = 32;
   localparam int unsigned OFS_W    = 8;
   localparam int unsigned LINE_W   = 2;

   // register byte offsets on the bus
   localparam logic [7:0] OFS_STATUS  = 8'h00;
   localparam logic [7:0] OFS_IRQ_EN  = 8'h04;
   localparam logic [7:0] OFS_IRQ_DIS = 8'h08;
   localparam logic [7:0] OFS_IRQ_MSK = 8'h0C;
   localparam logic [7:0] OFS_MODE    = 8'h10;

   // status bit positions; bits 0 to 7 also serve enable, disable and mask
   localparam int unsigned BIT_WRAP      = 0;
   localparam int unsigned BIT_OVERRUN   = 1;
   localparam int unsigned BIT_MATCH_1   = 2;
   localparam int unsigned BIT_MATCH_2   = 3;
   localparam int unsigned BIT_LIMIT     = 4;
   localparam int unsigned BIT_LOAD_1    = 5;
   localparam int unsigned BIT_LOAD_2    = 6;
   localparam int unsigned BIT_TRIGGER   = 7;
   localparam int unsigned BIT_CLK_RUN   = 16;
   localparam int unsigned BIT_LINE_A    = 17;
   localparam int unsigned BIT_LINE_B    = 18;

   // flags that only exist in one of the two modes
   localparam logic [7:0] CAPTURE_ONLY = 8'h62;
   localparam logic [7:0] WAVE_ONLY    = 8'h0C;

   // channel mode register fields
   localparam int unsigned MODE_WAVE_BIT  = 0;
   localparam int unsigned MODE_DLIM_BIT  = 1;
   localparam int unsigned MODE_W         = 2;

   // reset values
   localparam logic [7:0]  MASK_RESET  = 8'h00;
   localparam logic [7:0]  FLAG_RESET  = 8'h00;
   localparam logic [1:0]  MODE_RESET  = 2'h0;
   localparam logic [31:0] WORD_ZERO   = 32'h0000_0000;

   // bus encodings
   localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
   localparam logic        HRESP_OKAY    = 1'h0;

   // line index for the pin synchroniser
   localparam int unsigned LINE_A = 0;
   localparam int unsigned LINE_B = 1;

endpackage

// ===== logic/tcs_flag_if.sv
// carrier between the register slave and the sticky flag bank
interface tcs_flag_if;
   logic [tcs_pkg::FLAG_W-1:0] set_vec;
   logic                       clear_all;
   logic [tcs_pkg::FLAG_W-1:0] ena_vec;
   logic [tcs_pkg::FLAG_W-1:0] dis_vec;
   logic [tcs_pkg::FLAG_W-1:0] flags;
   logic [tcs_pkg::FLAG_W-1:0] mask;

   modport bank
   (
      input  set_vec,
      input  clear_all,
      input  ena_vec,
      input  dis_vec,
      output flags,
      output mask
   );

   modport ctrl
   (
      output set_vec,
      output clear_all,
      output ena_vec,
      output dis_vec,
      input  flags,
      input  mask
   );
endinterface

// ===== logic/tcs_sync.sv
// three-stage synchroniser for pin levels, change taken on agreement
module tcs_sync
#(
   parameter int unsigned WIDTH = 2
)
(
   input  wire logic             hclk,
   input  wire logic             hresetn,
   input  wire logic [WIDTH-1:0] pin_in,
   output logic      [WIDTH-1:0] level
);

   logic [WIDTH-1:0] s1_q;
   logic [WIDTH-1:0] s2_q;
   logic [WIDTH-1:0] s3_q;
   logic [WIDTH-1:0] level_q;

   // first stage feeds only the second
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
      end
      else
      begin
         s1_q <= pin_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // a new level counts only once stages two and three agree
   genvar i;
   generate
      for (i = 0; i < WIDTH; i++)
      begin : g_line
         always_ff @(posedge hclk or negedge hresetn)
         begin
            if (!hresetn)
               level_q[i] <= 1'b0;
            else if (s2_q[i] == s3_q[i])
               level_q[i] <= s3_q[i];
         end
      end
   endgenerate

   assign level = level_q;

endmodule

// ===== logic/tcs_flags.sv
// sticky event flags and interrupt mask, one slice per source
module tcs_flags
#(
   parameter int unsigned N = tcs_pkg::FLAG_W
)
(
   input  wire logic hclk,
   input  wire logic hresetn,
   tcs_flag_if.bank  fl
);

   genvar i;
   generate
      for (i = 0; i < N; i++)
      begin : g_src
         // set beats the read-clear so no event is lost
         always_ff @(posedge hclk or negedge hresetn)
         begin
            if (!hresetn)
               fl.flags[i] <= tcs_pkg::FLAG_RESET[i];
            else if (fl.set_vec[i])
               fl.flags[i] <= 1'b1;
            else if (fl.clear_all)
               fl.flags[i] <= 1'b0;
         end

         // enable sets, disable clears; both at once leaves it disabled
         always_ff @(posedge hclk or negedge hresetn)
         begin
            if (!hresetn)
               fl.mask[i] <= tcs_pkg::MASK_RESET[i];
            else if (fl.dis_vec[i])
               fl.mask[i] <= 1'b0;
            else if (fl.ena_vec[i])
               fl.mask[i] <= 1'b1;
         end
      end
   endgenerate

endmodule

// ===== logic/tcs_top.sv
// timer channel status flags, interrupt mask and ahb-lite register slave
//
// Notes on behaviour
// - wrap sets bit 0, read clears
// - capture mode: double load sets overrun
// - waveform mode: first match sets bit 2
// - waveform mode: second match sets bit 3
// - limit match sets bit 4, any mode
// - capture mode: loads set bits 5, 6
// - external trigger sets bit 7
// - bit 16 shows live clock enable
// - bit 17 mirrors line A
// - bit 18 mirrors line B
// - enable register ones set mask bits
// - disable register ones clear mask bits
// - mask register reads enable state
// - enable, disable, mask share flag layout
// - status bits 18, 17, 16 placed
// - mode bit: zero capture, one waveform
// - disable-on-limit stops counter clock
//
// Chosen here: register access over AHB-Lite and the register offsets.
module tcs_top
(
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire logic        wrap_evt,
   input  wire logic        first_match_evt,
   input  wire logic        second_match_evt,
   input  wire logic        limit_match_evt,
   input  wire logic        first_load_evt,
   input  wire logic        second_load_evt,
   input  wire logic        first_hold_read,
   input  wire logic        second_hold_read,
   input  wire logic        ext_trigger_evt,
   input  wire logic        clock_enable_cmd,
   input  wire logic        clock_disable_cmd,
   input  wire logic        channel_line_a_in,
   input  wire logic        channel_line_b_in,
   input  wire logic        channel_line_a_drive,
   input  wire logic        channel_line_b_drive,
   output logic             counter_clock_en,
   output logic             wave_mode,
   output logic             irq
);

   // bus side state
   logic                    rd_phase;
   logic                    wr_phase;
   logic [tcs_pkg::OFS_W-1:0] req_ofs;
   logic                    wr_pend_q;
   logic [tcs_pkg::OFS_W-1:0] wr_ofs_q;
   logic [31:0]             hrdata_q;
   logic [31:0]             rd_word;
   logic                    hreadyout_q;
   logic                    hresp_q;

   // two hold registers, each watched for an overrun of its own
   localparam int unsigned N_HOLD = 2;

   // block state
   logic [tcs_pkg::MODE_W-1:0] mode_q;
   logic                    wave;
   logic                    dis_on_limit;
   logic                    clk_run_q;
   logic [N_HOLD-1:0]       load_pend_q;
   logic [N_HOLD-1:0]       load_evt;
   logic [N_HOLD-1:0]       hold_read;
   logic                    overrun_evt;
   logic                    status_rd;
   logic [tcs_pkg::LINE_W-1:0] pin_level;
   logic                    mirror_a_q;
   logic                    mirror_b_q;
   logic [tcs_pkg::FLAG_W-1:0] flag_view;
   logic [tcs_pkg::FLAG_W-1:0] set_d;
   logic [tcs_pkg::FLAG_W-1:0] ena_d;
   logic [tcs_pkg::FLAG_W-1:0] dis_d;
   logic [31:0]             status_word;
   logic                    irq_q;

   tcs_flag_if fl ();

   // pin levels cross in from outside the clock domain
   tcs_sync
   #(
      .WIDTH   (tcs_pkg::LINE_W)
   )
   u_sync
   (
      .hclk    (hclk),
      .hresetn (hresetn),
      .pin_in  ({channel_line_b_in, channel_line_a_in}),
      .level   (pin_level)
   );

   tcs_flags
   #(
      .N       (tcs_pkg::FLAG_W)
   )
   u_flags
   (
      .hclk    (hclk),
      .hresetn (hresetn),
      .fl      (fl.bank)
   );

   // mode decode; the mode bit decides which flags may set and show
   assign wave         = mode_q[tcs_pkg::MODE_WAVE_BIT];
   assign dis_on_limit = mode_q[tcs_pkg::MODE_DLIM_BIT];

   // address phase qualification; only word accesses are expected
   assign req_ofs  = haddr[tcs_pkg::OFS_W-1:0];
   assign rd_phase = hsel & hready & (htrans == tcs_pkg::HTRANS_NONSEQ)
                     & ~hwrite;
   assign wr_phase = hsel & hready & (htrans == tcs_pkg::HTRANS_NONSEQ)
                     & hwrite;

   // a status read clears flags on its address-phase edge; reads of
   // any other register leave the flags alone
   assign status_rd = rd_phase & (req_ofs == tcs_pkg::OFS_STATUS);

   // a write is applied in its data phase, where hwdata stands
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         wr_pend_q <= 1'b0;
      else
         wr_pend_q <= wr_phase;
   end

   // write offset held for that data phase
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         wr_ofs_q <= '0;
      else if (wr_phase)
         wr_ofs_q <= req_ofs;
   end

   // channel mode register, written by software
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         mode_q <= tcs_pkg::MODE_RESET;
      else if (wr_pend_q && wr_ofs_q == tcs_pkg::OFS_MODE)
         mode_q <= hwdata[tcs_pkg::MODE_W-1:0];
   end

   // enable and disable writes become one-cycle pulse vectors
   always_comb
   begin
      ena_d = '0;
      dis_d = '0;
      if (wr_pend_q && wr_ofs_q == tcs_pkg::OFS_IRQ_EN)
         ena_d = hwdata[tcs_pkg::FLAG_W-1:0];
      if (wr_pend_q && wr_ofs_q == tcs_pkg::OFS_IRQ_DIS)
         dis_d = hwdata[tcs_pkg::FLAG_W-1:0];
   end

   // one pending marker per hold register; a load while still unread
   // marks it, a read of that register or of status forgets it
   assign load_evt  = {second_load_evt, first_load_evt};
   assign hold_read = {second_hold_read, first_hold_read};

   genvar h;
   generate
      for (h = 0; h < N_HOLD; h++)
      begin : g_hold
         always_ff @(posedge hclk or negedge hresetn)
         begin
            if (!hresetn)
               load_pend_q[h] <= 1'b0;
            else if (load_evt[h] && !wave)
               load_pend_q[h] <= 1'b1;
            else if (hold_read[h] || status_rd)
               load_pend_q[h] <= 1'b0;
         end
      end
   endgenerate

   // a second load before any read is an overrun; the hold registers
   // are tracked apart so a read of one never hides the other
   assign overrun_evt = |(load_evt & load_pend_q);

   // event sources, gated by the mode they belong to
   always_comb
   begin
      set_d = '0;
      set_d[tcs_pkg::BIT_WRAP]    = wrap_evt;
      set_d[tcs_pkg::BIT_OVERRUN] = ~wave & overrun_evt;
      set_d[tcs_pkg::BIT_MATCH_1] = wave & first_match_evt;
      set_d[tcs_pkg::BIT_MATCH_2] = wave & second_match_evt;
      set_d[tcs_pkg::BIT_LIMIT]   = limit_match_evt;
      set_d[tcs_pkg::BIT_LOAD_1]  = ~wave & first_load_evt;
      set_d[tcs_pkg::BIT_LOAD_2]  = ~wave & second_load_evt;
      set_d[tcs_pkg::BIT_TRIGGER] = ext_trigger_evt;
   end

   // hook the flag bank up
   assign fl.set_vec   = set_d;
   assign fl.clear_all = status_rd;
   assign fl.ena_vec   = ena_d;
   assign fl.dis_vec   = dis_d;

   // flags left over from the other mode read as zero
   // after a mode switch rather than being wiped
   always_comb
   begin
      flag_view = fl.flags;
      if (wave)
         flag_view = flag_view & ~tcs_pkg::CAPTURE_ONLY;
      else
         flag_view = flag_view & ~tcs_pkg::WAVE_ONLY;
   end

   // counter clock enable; a disable always wins over an enable
   // after a limit stop software must enable the clock again
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         clk_run_q <= 1'b0;
      else if (clock_disable_cmd)
         clk_run_q <= 1'b0;
      else if (dis_on_limit && limit_match_evt)
         clk_run_q <= 1'b0;
      else if (clock_enable_cmd)
         clk_run_q <= 1'b1;
   end

   // line mirrors: sampled pin in capture, driven level in waveform
   // pin levels trail the pins by the synchroniser's depth
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         mirror_a_q <= 1'b0;
         mirror_b_q <= 1'b0;
      end
      else if (wave)
      begin
         mirror_a_q <= channel_line_a_drive;
         mirror_b_q <= channel_line_b_drive;
      end
      else
      begin
         mirror_a_q <= pin_level[tcs_pkg::LINE_A];
         mirror_b_q <= pin_level[tcs_pkg::LINE_B];
      end
   end

   // status word; bits not named read as zero
   always_comb
   begin
      status_word = tcs_pkg::WORD_ZERO;
      status_word[tcs_pkg::FLAG_W-1:0] = flag_view;
      status_word[tcs_pkg::BIT_CLK_RUN] = clk_run_q;
      status_word[tcs_pkg::BIT_LINE_A]  = mirror_a_q;
      status_word[tcs_pkg::BIT_LINE_B]  = mirror_b_q;
   end

   // read mux; write-only and unmapped offsets return zero
   always_comb
   begin
      rd_word = tcs_pkg::WORD_ZERO;
      case (req_ofs)
         tcs_pkg::OFS_STATUS:
            rd_word = status_word;
         tcs_pkg::OFS_IRQ_MSK:
            rd_word[tcs_pkg::FLAG_W-1:0] = fl.mask;
         tcs_pkg::OFS_MODE:
            rd_word[tcs_pkg::MODE_W-1:0] = mode_q;
         // write-only registers: a read is harmless and shows zero
         tcs_pkg::OFS_IRQ_EN,
         tcs_pkg::OFS_IRQ_DIS:
            rd_word = tcs_pkg::WORD_ZERO;
         default:
            rd_word = tcs_pkg::WORD_ZERO;
      endcase
   end

   // read data are caught at the address-phase edge so the status
   // snapshot holds the visible flags as they stood before this read clears all eight
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         hrdata_q <= tcs_pkg::WORD_ZERO;
      else if (rd_phase)
         hrdata_q <= rd_word;
   end

   // zero-wait slave: every register answers at once
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         hreadyout_q <= 1'b1;
      else
         hreadyout_q <= 1'b1;
   end

   // nothing is refused, so the response is always okay; a flop
   // keeps the output straight from a register
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         hresp_q <= tcs_pkg::HRESP_OKAY;
      else
         hresp_q <= tcs_pkg::HRESP_OKAY;
   end

   // interrupt request from visible flags and mask
   // registered, so irq trails the flags by one cycle
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         irq_q <= 1'b0;
      else
         irq_q <= |(flag_view & fl.mask);
   end

   // hsize is accepted as-is; narrow transfers behave as word ones
   logic unused_size;
   assign unused_size = ^hsize;

   // outputs, each from a flop
   assign hrdata           = hrdata_q;
   assign hreadyout        = hreadyout_q;
   assign hresp            = hresp_q;
   assign counter_clock_en = clk_run_q;
   assign wave_mode        = mode_q[tcs_pkg::MODE_WAVE_BIT];
   assign irq              = irq_q;

endmodule

// ===== sim/tcs_top_monitor.sv
// port-level assertion checker for the timer channel status block
module tcs_top_monitor
(
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [31:0] hwdata,
   input wire logic        hready,
   input wire logic [31:0] hrdata,
   input wire logic        wrap_evt,
   input wire logic        first_match_evt,
   input wire logic        second_match_evt,
   input wire logic        limit_match_evt,
   input wire logic        first_load_evt,
   input wire logic        second_load_evt,
   input wire logic        ext_trigger_evt,
   input wire logic        clock_enable_cmd,
   input wire logic        clock_disable_cmd,
   input wire logic        counter_clock_en,
   input wire logic        wave_mode,
   input wire logic        irq
);
   timeunit 1ns;
   timeprecision 1ps;
   logic       rd_q;
   logic       rd_st_q;
   logic       rd_z_q;
   logic       wr_md_q;
   wire  [7:0] ofs  = haddr[7:0];
   wire        take = hsel && hready && htrans == tcs_pkg::HTRANS_NONSEQ;
   wire        evt  = wrap_evt | first_match_evt | second_match_evt |
                      limit_match_evt | first_load_evt | second_load_evt |
                      ext_trigger_evt;
   // address phase kinds, held into the data phase
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         rd_q    <= 1'b0;
         rd_st_q <= 1'b0;
         rd_z_q  <= 1'b0;
         wr_md_q <= 1'b0;
      end
      else
      begin
         rd_q    <= take && !hwrite;
         rd_st_q <= take && !hwrite && ofs == tcs_pkg::OFS_STATUS;
         rd_z_q  <= take && !hwrite && (ofs == tcs_pkg::OFS_IRQ_EN ||
                    ofs == tcs_pkg::OFS_IRQ_DIS || ofs > tcs_pkg::OFS_MODE);
         wr_md_q <= take && hwrite && ofs == tcs_pkg::OFS_MODE;
      end
   end
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   a_dis_stops: assert property
      (clock_disable_cmd |=> !counter_clock_en) else $error("clock not off");
   a_en_starts: assert property
      (clock_enable_cmd && !clock_disable_cmd && !limit_match_evt
       |=> counter_clock_en) else $error("clock not on");
   a_clk_hold: assert property
      (!clock_enable_cmd && !clock_disable_cmd && !limit_match_evt
       |=> $stable(counter_clock_en)) else $error("clock moved alone");
   a_read_clears: assert property
      (take && !hwrite && ofs == tcs_pkg::OFS_STATUS && !evt ##1 !evt
       |=> !irq) else $error("irq after status read");
   a_mode_write: assert property
      (wr_md_q |=> wave_mode == $past(hwdata[0])) else $error("mode lost");
   a_rdata_hold: assert property
      ($changed(hrdata) |-> rd_q) else $error("read data moved");
   a_status_resv: assert property
      (rd_st_q |-> hrdata[31:19] == 13'h0000 && hrdata[15:8] == 8'h00)
      else $error("reserved status bits set");
   a_clk_mirror: assert property
      (rd_st_q |-> hrdata[16] == $past(counter_clock_en))
      else $error("clock bit wrong");
   a_mode_gate: assert property
      (rd_st_q |-> (hrdata[7:0] & ($past(wave_mode) ? tcs_pkg::CAPTURE_ONLY
       : tcs_pkg::WAVE_ONLY)) == 8'h00) else $error("flag of other mode");
   a_wo_zero: assert property
      (rd_z_q |-> hrdata == 32'h0000_0000) else $error("nonzero read");
   // main scenarios
   c_irq: cover property ($rose(irq));
   c_limit_stop: cover property (limit_match_evt ##1 !counter_clock_en);
   c_wave_read: cover property (rd_st_q && wave_mode);
endmodule

bind tcs_top tcs_top_monitor mon (.*);

// ===== sim/testbench.sv
// self-checking bench for the timer channel status block
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [7:0]  ev;
   logic [3:0]  cmd;
   logic        channel_line_a_in, channel_line_b_in;
   logic        channel_line_a_drive, channel_line_b_drive;
   logic        counter_clock_en, wave_mode, irq;
   int          n_errors, n_compared;
   wire         wrap_evt          = ev[0];
   wire         first_match_evt   = ev[2];
   wire         second_match_evt  = ev[3];
   wire         limit_match_evt   = ev[4];
   wire         first_load_evt    = ev[5];
   wire         second_load_evt   = ev[6];
   wire         ext_trigger_evt   = ev[7];
   wire         clock_enable_cmd  = cmd[0];
   wire         clock_disable_cmd = cmd[1];
   wire         first_hold_read   = cmd[2];
   wire         second_hold_read  = cmd[3];
   assign hready = hreadyout;
   tcs_top uut (.*);
   // 40 MHz clock
   initial
   begin
      hclk = 1'b0;
      forever #12.5 hclk = ~hclk;
   end
   task automatic finish_test;
      $display("compared %0d errors %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                      input string what);
      n_compared++;
      if (got !== exp)
      begin
         n_errors++;
         $display("BAD %0t %s got %h want %h", $time, what, got, exp);
      end
   endtask
   // one ahb-lite single transfer; waits are bounded
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r);
      int k;
      @(posedge hclk);
      hsel   <= 1'b1;
      htrans <= tcs_pkg::HTRANS_NONSEQ;
      hwrite <= w;
      haddr  <= {24'h00_0000, a};
      for (int p = 0; p < 2; p++)
      begin
         k = 0;
         do
         begin
            @(posedge hclk);
            k++;
         end
         while (hready !== 1'b1 && k < 64);
         if (hready !== 1'b1)
         begin
            n_errors++;
            $display("BAD %0t bus wait expired", $time);
            finish_test();
         end
         if (p == 0)
         begin
            htrans <= 2'h0;
            hsel   <= 1'b0;
            hwdata <= d;
         end
      end
      r = hrdata;
      chk({31'h0, hresp}, {31'h0, tcs_pkg::HRESP_OKAY}, "hresp");
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      bus(1'b1, a, d, r);
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] e,
                        input string what);
      logic [31:0] r;
      bus(1'b0, a, 32'h0000_0000, r);
      chk(r, e, what);
   endtask
   // one-cycle pulse on event and command inputs
   task automatic fire(input logic [7:0] e, input logic [3:0] c);
      @(posedge hclk);
      ev  <= e;
      cmd <= c;
      @(posedge hclk);
      ev  <= 8'h00;
      cmd <= 4'h0;
   endtask
   // flags visible in a mode; overrun has no direct event
   function automatic logic [7:0] seen(input logic [7:0] e, input logic w);
      return e & 8'hFD & ~(w ? tcs_pkg::CAPTURE_ONLY : tcs_pkg::WAVE_ONLY);
   endfunction
   // main sequence
   initial
   begin
      logic [7:0] ofs [6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h40};
      logic [7:0] m, e;
      logic       w, pa, pb;
      {hresetn, hsel, hwrite, haddr, htrans, hwdata, ev, cmd} = '0;
      hsize = 3'h2;
      {channel_line_a_in, channel_line_b_in} = 2'h0;
      {channel_line_a_drive, channel_line_b_drive} = 2'h0;
      n_errors = 0;
      n_compared = 0;
      void'($urandom(32'hC430));
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      foreach (ofs[i])
         rdchk(ofs[i], 32'h0, "reset read");
      // random masks and events in both modes, corners first
      for (int i = 0; i < 40; i++)
      begin
         w = (i < 2) ? i[0] : 1'($urandom);
         m = 8'($urandom);
         e = (i < 2) ? 8'hFF : 8'($urandom);
         wr(tcs_pkg::OFS_MODE, {31'h0, w});
         wr(tcs_pkg::OFS_IRQ_EN, {24'h0, m});
         wr(tcs_pkg::OFS_IRQ_DIS, {24'hFF_FFFF, ~m});
         rdchk(tcs_pkg::OFS_IRQ_MSK, {24'h0, m}, "mask");
         fire(e, 4'h0);
         repeat (2) @(posedge hclk);
         chk({31'h0, irq}, {31'h0, |(seen(e, w) & m)}, "irq");
         rdchk(tcs_pkg::OFS_STATUS, {24'h0, seen(e, w)}, "flags");
         rdchk(tcs_pkg::OFS_STATUS, 32'h0, "cleared");
         chk({31'h0, irq}, 32'h0, "irq low");
      end
      // double loads, with and without a hold read between
      wr(tcs_pkg::OFS_MODE, 32'h0);
      fire(8'h20, 4'h0);
      fire(8'h20, 4'h0);
      rdchk(tcs_pkg::OFS_STATUS, 32'h22, "overrun");
      fire(8'h40, 4'h0);
      fire(8'h00, 4'h8);
      fire(8'h40, 4'h0);
      rdchk(tcs_pkg::OFS_STATUS, 32'h40, "read between loads");
      fire(8'h20, 4'h0);
      fire(8'h00, 4'h4);
      fire(8'h20, 4'h0);
      rdchk(tcs_pkg::OFS_STATUS, 32'h20, "first hold read");
      fire(8'h60, 4'h0);
      rdchk(tcs_pkg::OFS_STATUS, 32'h60, "both loads");
      fire(8'h60, 4'h0);
      rdchk(tcs_pkg::OFS_STATUS, 32'h60, "status read forgets");
      wr(tcs_pkg::OFS_MODE, 32'h1);
      fire(8'h60, 4'h0);
      fire(8'h60, 4'h0);
      rdchk(tcs_pkg::OFS_STATUS, 32'h0, "loads in wave mode");
      // counter clock on, limit without and with disable-on-limit
      fire(8'h00, 4'h1);
      rdchk(tcs_pkg::OFS_STATUS, 32'h1_0000, "clock on");
      fire(8'h10, 4'h0);
      rdchk(tcs_pkg::OFS_STATUS, 32'h1_0010, "limit kept");
      wr(tcs_pkg::OFS_MODE, 32'h2);
      fire(8'h10, 4'h0);
      rdchk(tcs_pkg::OFS_STATUS, 32'h10, "limit stop");
      fire(8'h00, 4'h1);
      fire(8'h00, 4'h2);
      rdchk(tcs_pkg::OFS_STATUS, 32'h0, "clock off");
      // pins and drives differ so the wrong source shows
      for (int i = 0; i < 8; i++)
      begin
         w  = i[0];
         pa = 1'($urandom);
         pb = 1'($urandom);
         wr(tcs_pkg::OFS_MODE, {31'h0, w});
         @(posedge hclk);
         channel_line_a_in    <= pa ^ w;
         channel_line_b_in    <= pb ^ w;
         channel_line_a_drive <= pa ^ !w;
         channel_line_b_drive <= pb ^ !w;
         repeat (8) @(posedge hclk);
         rdchk(tcs_pkg::OFS_STATUS, {13'h0, pb, pa, 17'h0}, "mirror");
      end
      finish_test();
   end
endmodule
